// ===== shift_branch_unit.sv
// Shift and subtract-then-branch execution unit with an AHB-Lite register slave
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
module shift_branch_unit
  import shift_branch_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             busy,
  output logic             branch_taken
);

  // Bus slave state
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] ctrl_r;
  logic [31:0] src_r;
  logic [31:0] dest_r;
  logic [31:0] pc_r;
  logic [31:0] label_r;
  logic [3:0]  flags_r;
  logic [31:0] result_r;
  logic [2:0]  status_r;
  logic [31:0] next_pc_r;
  logic        start_r;

  // Execution results
  logic [31:0] res_nxt;
  logic [3:0]  flags_nxt;
  logic        branch_nxt;
  logic        range_nxt;
  logic [31:0] next_pc_nxt;

  op_t         op;
  size_t       sz;
  logic        addr_ok;

  assign op      = op_t'(ctrl_r[CTRL_OP_LSB +: 2]);
  assign sz      = size_t'(ctrl_r[CTRL_SIZE_LSB +: 2]);
  assign addr_ok = hsel && htrans[1] && hready;

  // Width mask per size
  function automatic logic [31:0] size_mask(input size_t s);
    unique case (s)
      SZ_BYTE: size_mask = 32'h0000_00ff;
      SZ_WORD: size_mask = 32'h0000_ffff;
      default: size_mask = 32'hffff_ffff;
    endcase
  endfunction : size_mask

  // MSB position per size
  function automatic int msb_pos(input size_t s);
    unique case (s)
      SZ_BYTE: msb_pos = 7;
      SZ_WORD: msb_pos = 15;
      default: msb_pos = 31;
    endcase
  endfunction : msb_pos

  // Keep the program counter width only
  function automatic logic [31:0] pc_trim(input logic [31:0] w);
    pc_trim = {{(32 - PC_W){1'b0}}, w[PC_W-1:0]};
  endfunction : pc_trim

  // Combinational execution of one instruction
  always_comb begin
    logic signed [7:0]  cnt;
    logic [5:0]         mag;
    logic [31:0]        val;
    logic [31:0]        m;
    logic               msb0;
    logic               carry;
    logic               ovf;
    logic               fill;
    logic signed [31:0] disp;
    int                 top;
    logic [31:0]        imm_ext;
    logic [31:0]        addend;
    logic [31:0]        diff;
    cnt         = signed'(src_r[7:0]);
    mag         = 6'h00;
    m           = size_mask(sz);
    top         = msb_pos(sz);
    val         = dest_r & m;
    msb0        = val[top];
    carry       = flags_r[FLG_C_BIT];
    ovf         = 1'b0;
    fill        = 1'b0;
    disp        = 32'(signed'(label_r)) - 32'(signed'(pc_r));
    res_nxt     = dest_r;
    flags_nxt   = flags_r;
    branch_nxt  = 1'b0;
    range_nxt   = 1'b1;
    next_pc_nxt = pc_r;
    imm_ext     = {{24{src_r[7]}}, src_r[7:0]};
    addend      = RST_WORD;
    diff        = RST_WORD;
    unique case (op)
      OP_SUB_JUMP: begin
        addend = ~imm_ext + 32'h0000_0001;
        diff    = (dest_r + addend) & m;
        res_nxt = (dest_r & ~m) | diff;
        branch_nxt = (diff != 32'h0000_0000);
        range_nxt = (disp >= BR_DISP_MIN) && (disp <= BR_DISP_MAX);
        // choose jump target or fall through
        next_pc_nxt = (branch_nxt && range_nxt) ? label_r : pc_r;
        flags_nxt = flags_r;
      end
      OP_ARITH_SHIFT, OP_LOGIC_SHIFT: begin
        mag = 6'(cnt < 0 ? -cnt : cnt);
        // sign fill only for arithmetic right
        fill = (op == OP_ARITH_SHIFT) && (cnt < 0) && msb0;
        for (int i = 0; i < CNT_WIDE_LIMIT; i++) begin
          if (i < int'(mag)) begin
            if (cnt > 0) begin
              carry = val[top];
              val   = (val << 1) & m;
            end else begin
              carry = val[0];
              val   = val >> 1;
              val[top] = fill;
            end
            if (val[top] != msb0) begin
              ovf = 1'b1;
            end
          end
        end
        if (cnt != 8'sd0) begin
          res_nxt = (dest_r & ~m) | val;
          flags_nxt[FLG_S_BIT] = val[top];
          flags_nxt[FLG_Z_BIT] = (val == 32'h0000_0000);
          flags_nxt[FLG_C_BIT] = carry;
          // overflow on MSB change for arithmetic shifts only, kept in long and in logical shifts
          if (op == OP_ARITH_SHIFT && sz != SZ_LONG) begin
            flags_nxt[FLG_O_BIT] = ovf;
          end
        end
      end
      default: begin
      end
    endcase
  end

  // Address phase capture for writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= addr_ok && hwrite && (hsize == 3'b010);
      wr_addr_r <= haddr;
    end
  end

  // Read data, driven in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= RST_WORD;
    end else if (addr_ok && !hwrite) begin
      unique case (haddr)
        OFS_CTRL:    hrdata <= ctrl_r;
        OFS_SRC:     hrdata <= src_r;
        OFS_DEST:    hrdata <= dest_r;
        OFS_PC:      hrdata <= pc_r;
        OFS_LABEL:   hrdata <= label_r;
        OFS_FLAGS:   hrdata <= {28'h0000000, flags_r};
        OFS_RESULT:  hrdata <= result_r;
        OFS_STATUS:  hrdata <= {29'h00000000, status_r};
        OFS_NEXT_PC: hrdata <= next_pc_r;
        default:     hrdata <= RST_WORD;
      endcase
    end
  end

  // Zero wait-state OKAY slave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Start pulse for one execution
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_r <= 1'b0;
    end else begin
      start_r <= wr_pend_r && (wr_addr_r == OFS_CTRL) && hwdata[CTRL_START_BIT];
    end
  end

  // Control register, start bit not kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= RST_WORD;
    end else if (wr_pend_r && wr_addr_r == OFS_CTRL) begin
      ctrl_r <= hwdata & 32'h0000_003e;
    end
  end

  // Source operand
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_r <= RST_WORD;
    end else if (wr_pend_r && wr_addr_r == OFS_SRC) begin
      src_r <= hwdata;
    end
  end

  // Start address of the current operation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_r <= RST_WORD;
    end else if (wr_pend_r && wr_addr_r == OFS_PC) begin
      pc_r <= pc_trim(hwdata);
    end
  end

  // Branch label
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      label_r <= RST_WORD;
    end else if (wr_pend_r && wr_addr_r == OFS_LABEL) begin
      label_r <= pc_trim(hwdata);
    end
  end

  // Destination: execution wins over a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dest_r <= RST_WORD;
    end else if (start_r) begin
      dest_r <= res_nxt;
    end else if (wr_pend_r && wr_addr_r == OFS_DEST) begin
      dest_r <= hwdata;
    end
  end

  // Flags: execution wins over a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= RST_FLAGS;
    end else if (start_r) begin
      flags_r <= flags_nxt;
    end else if (wr_pend_r && wr_addr_r == OFS_FLAGS) begin
      flags_r <= hwdata[3:0];
    end
  end

  // Result word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_r <= RST_WORD;
    end else if (start_r) begin
      result_r <= res_nxt;
    end
  end

  // Next program counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      next_pc_r <= RST_WORD;
    end else if (start_r) begin
      next_pc_r <= next_pc_nxt;
    end
  end

  // Execution status, done cleared by a new control write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r <= 3'b000;
    end else if (start_r) begin
      status_r[ST_DONE_BIT]   <= 1'b1;
      status_r[ST_RANGE_BIT]  <= range_nxt;
      status_r[ST_BRANCH_BIT] <= branch_nxt && range_nxt;
    end else if (wr_pend_r && wr_addr_r == OFS_CTRL) begin
      status_r[ST_DONE_BIT] <= 1'b0;
    end
  end

  // Branch decision output
  // taken only inside window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      branch_taken <= 1'b0;
    end else if (start_r) begin
      branch_taken <= branch_nxt && range_nxt;
    end
  end

  // One-cycle execution marker
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
    end else begin
      busy <= wr_pend_r && (wr_addr_r == OFS_CTRL) && hwdata[CTRL_START_BIT];
    end
  end

endmodule : shift_branch_unit

// ===== shift_branch_pkg.sv
// Package of constants and types for the shift and subtract-branch unit
package shift_branch_pkg;

  // Operation select
  typedef enum logic [1:0] {
    OP_NONE,
    OP_SUB_JUMP,
    OP_ARITH_SHIFT,
    OP_LOGIC_SHIFT
  } op_t;

  // Operand size select
  typedef enum logic [1:0] {
    SZ_BYTE,
    SZ_WORD,
    SZ_LONG
  } size_t;

  // Register map (AHB-Lite byte addresses)
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_SRC     = 8'h04;
  localparam logic [7:0] OFS_DEST    = 8'h08;
  localparam logic [7:0] OFS_PC      = 8'h0c;
  localparam logic [7:0] OFS_LABEL   = 8'h10;
  localparam logic [7:0] OFS_FLAGS   = 8'h14;
  localparam logic [7:0] OFS_RESULT  = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1c;
  localparam logic [7:0] OFS_NEXT_PC = 8'h20;

  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_LSB    = 1;
  localparam int CTRL_SIZE_LSB  = 3;
  localparam int CTRL_IMM_BIT   = 5;

  // Flags register fields
  localparam int FLG_C_BIT = 0;
  localparam int FLG_Z_BIT = 1;
  localparam int FLG_S_BIT = 2;
  localparam int FLG_O_BIT = 3;

  // Status register fields
  localparam int ST_BRANCH_BIT = 0;
  localparam int ST_RANGE_BIT  = 1;
  localparam int ST_DONE_BIT   = 2;

  // Documented ranges
  localparam int SUB_IMM_MIN    = -7;
  localparam int SUB_IMM_MAX    = 8;
  localparam int BR_DISP_MIN    = -126;
  localparam int BR_DISP_MAX    = 129;
  localparam int CNT_BYTE_LIMIT = 8;
  localparam int CNT_WIDE_LIMIT = 16;

  // Reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [3:0]  RST_FLAGS = 4'h0;

  // Width of the program counter
  localparam int PC_W = 20;

endpackage : shift_branch_pkg

// ===== shift_branch_monitor.sv
// Checker of bus timing and execution timing for the shift and subtract-branch unit
module shift_branch_monitor
  import shift_branch_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        busy,
  input wire logic        branch_taken
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic ap_ok;
  logic wr_ctrl;
  assign ap_ok   = hsel && htrans == 2'b10 && hready;
  assign wr_ctrl = ap_ok && hwrite && hsize == 3'b010 && haddr == OFS_CTRL;
  a_ready_high: assert property (hreadyout) else $error("wait state inserted");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_busy_single: assert property (busy |=> !busy) else $error("busy longer than one cycle");
  a_start_busy: assert property (wr_ctrl ##1 hwdata[0] |=> busy)
    else $error("start did not raise busy");
  a_busy_cause: assert property ($rose(busy) |-> $past(wr_ctrl, 2) && $past(hwdata[0]))
    else $error("busy without start");
  a_branch_exec: assert property ($changed(branch_taken) |-> $past(busy))
    else $error("branch changed outside execution");
  a_unmapped_zero: assert property (ap_ok && !hwrite && haddr == 8'h40 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!$past(ap_ok && !hwrite) |-> $stable(hrdata))
    else $error("read data changed without read");
  c_busy: cover property (busy);
  c_branch: cover property ($rose(branch_taken));
  c_fall: cover property ($fell(branch_taken));
endmodule : shift_branch_monitor

bind shift_branch_unit shift_branch_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy),
  .branch_taken(branch_taken));

// ===== exec_ref_model.sv
// Reference of the decoder and register side: expected destination and flags
module exec_ref_model
  import shift_branch_pkg::*;
(
  input  wire logic [1:0]  op,
  input  wire logic [1:0]  size,
  input  wire logic [7:0]  src,
  input  wire logic [31:0] dest,
  input  wire logic [3:0]  flags,
  output logic      [31:0] exp_dest,
  output logic      [3:0]  exp_flags
);
  logic [31:0] d, m, mb;
  int          w, n, k;
  always_comb begin
    w = (size == 2'd0) ? 8 : (size == 2'd1) ? 16 : 32;
    m = (w == 32) ? 32'hffff_ffff : (32'h1 << w) - 32'h1;
    mb = 32'h1 << (w - 1);
    d = dest & m;
    n = int'($signed(src));
    k = (n < 0) ? -n : n;
    exp_flags = flags;
    if (op == OP_SUB_JUMP) d = (d - {{24{src[7]}}, src}) & m;
    else if (op != OP_NONE && n != 0) begin
      if (op == OP_ARITH_SHIFT && w != 32) exp_flags[3] = 1'b0;
      for (int i = 0; i < 16; i++) begin
        if (i < k) begin
          exp_flags[0] = (n > 0) ? |(d & mb) : d[0];
          if (n > 0) d = (d << 1) & m;
          else d = (d >> 1) | ((op == OP_ARITH_SHIFT) ? (d & mb) : 32'h0);
          if (op == OP_ARITH_SHIFT && w != 32 && (d & mb) != (dest & mb)) exp_flags[3] = 1'b1;
        end
      end
      exp_flags[1] = (d == 32'h0);
      exp_flags[2] = |(d & mb);
    end
    exp_dest = (dest & ~m) | d;
  end
endmodule : exec_ref_model

// ===== tb_shift_branch_unit.sv
// Testbench for the shift and subtract-branch unit
module tb_shift_branch_unit
  import shift_branch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite;
  logic [7:0]  haddr, m_src;
  logic [1:0]  htrans, m_op, m_size;
  logic [2:0]  hsize;
  logic [31:0] hwdata, m_dest, e_dest;
  logic [3:0]  m_flags, e_flags;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, busy, branch_taken;
  int          n_fail = 0, compares = 0, cyc = 0;
  shift_branch_unit dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy),
    .branch_taken(branch_taken));
  exec_ref_model u_ref (.op(m_op), .size(m_size), .src(m_src), .dest(m_dest),
    .flags(m_flags), .exp_dest(e_dest), .exp_flags(e_flags));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic run(input logic [1:0] op, input logic [1:0] sz, input logic [7:0] s,
                     input logic [31:0] d, input logic [3:0] f);
    logic [31:0] rd;
    m_op = op;
    m_size = sz;
    m_src = s;
    m_dest = d;
    m_flags = f;
    bus(1'b1, OFS_SRC, {24'h0, s}, rd);
    bus(1'b1, OFS_DEST, d, rd);
    bus(1'b1, OFS_FLAGS, {28'h0, f}, rd);
    bus(1'b1, OFS_CTRL, {27'h0, sz, op, 1'b1}, rd);
    @(negedge hclk);
    chk({31'h0, busy}, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    bus(1'b0, OFS_DEST, 32'h0, rd);
    chk(rd, e_dest);
    bus(1'b0, OFS_RESULT, 32'h0, rd);
    chk(rd, e_dest);
    bus(1'b0, OFS_FLAGS, 32'h0, rd);
    chk(rd, {28'h0, e_flags});
  endtask : run
  task automatic sj(input int off, input logic [7:0] s, input logic [31:0] d,
                    input logic [1:0] sz, input logic br);
    logic [31:0] rd;
    logic [19:0] lbl;
    logic        rng;
    lbl = 20'h01000 + off[19:0];
    rng = (off >= BR_DISP_MIN) && (off <= BR_DISP_MAX);
    bus(1'b1, OFS_PC, 32'h0000_1000, rd);
    bus(1'b1, OFS_LABEL, {12'h0, lbl}, rd);
    run(OP_SUB_JUMP, sz, s, d, 4'h5);
    chk({31'h0, branch_taken}, {31'h0, br});
    bus(1'b0, OFS_NEXT_PC, 32'h0, rd);
    chk(rd, br ? {12'h0, lbl} : 32'h0000_1000);
    bus(1'b0, OFS_STATUS, 32'h0, rd);
    chk(rd, {29'h0, 1'b1, rng, br});
  endtask : sj
  task automatic t_idle();
    logic [31:0] rd;
    bus(1'b0, 8'h40, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b0, OFS_FLAGS, 32'h0, rd);
    chk(rd, 32'h0);
  endtask : t_idle
  task automatic t_shift();
    run(OP_ARITH_SHIFT, SZ_BYTE, 8'h03, 32'h1234_5641, 4'h0);
    run(OP_ARITH_SHIFT, SZ_BYTE, 8'hfd, 32'h0000_0090, 4'h0);
    run(OP_ARITH_SHIFT, SZ_WORD, 8'h10, 32'h0000_8001, 4'h0);
    run(OP_ARITH_SHIFT, SZ_LONG, 8'hf0, 32'h8000_0000, 4'h8);
    run(OP_LOGIC_SHIFT, SZ_BYTE, 8'hfd, 32'h0000_0090, 4'h0);
    run(OP_LOGIC_SHIFT, SZ_BYTE, 8'h08, 32'h0000_0001, 4'h8);
    run(OP_LOGIC_SHIFT, SZ_BYTE, 8'hf8, 32'h0000_0080, 4'h0);
    run(OP_LOGIC_SHIFT, SZ_LONG, 8'h01, 32'h4000_0001, 4'h0);
  endtask : t_shift
  task automatic t_zero();
    run(OP_ARITH_SHIFT, SZ_WORD, 8'h00, 32'h0000_1234, 4'hf);
    run(OP_LOGIC_SHIFT, SZ_BYTE, 8'h00, 32'h0000_0000, 4'h6);
  endtask : t_zero
  task automatic t_sub();
    sj(4, 8'h01, 32'h0000_0105, SZ_BYTE, 1'b1);
    sj(4, 8'h05, 32'h0000_0005, SZ_BYTE, 1'b0);
    sj(-126, 8'h01, 32'h0000_0003, SZ_BYTE, 1'b1);
    sj(129, 8'hf9, 32'h0000_ffff, SZ_WORD, 1'b1);
    sj(130, 8'h01, 32'h0000_0003, SZ_BYTE, 1'b0);
    sj(-127, 8'h01, 32'h0000_0003, SZ_WORD, 1'b0);
  endtask : t_sub
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 8'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_idle();
    t_shift();
    t_zero();
    t_sub();
    finish_test();
  end
endmodule : tb_shift_branch_unit
